/* common/mpgio_pkg.sv */
// Constants, register map and state layout of the multi-port GPIO block.
// ==========================================================================
package mpgio_pkg;

  // ========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_A_DATA   = 10'h005;
  localparam logic [9:0] IDX_B_DATA   = 10'h006;
  localparam logic [9:0] IDX_B_DATA_M = 10'h106;
  localparam logic [9:0] IDX_C_DATA   = 10'h007;
  localparam logic [9:0] IDX_D_DATA   = 10'h008;
  localparam logic [9:0] IDX_INTCTL   = 10'h00B;
  localparam logic [9:0] IDX_INTCTL_M = 10'h08B;
  localparam logic [9:0] IDX_OPTION   = 10'h081;
  localparam logic [9:0] IDX_OPTION_M = 10'h181;
  localparam logic [9:0] IDX_A_DIR    = 10'h085;
  localparam logic [9:0] IDX_B_DIR    = 10'h086;
  localparam logic [9:0] IDX_B_DIR_M  = 10'h186;
  localparam logic [9:0] IDX_C_DIR    = 10'h087;
  localparam logic [9:0] IDX_D_DIR    = 10'h088;
  localparam logic [9:0] IDX_E_DIR    = 10'h089;
  localparam logic [9:0] IDX_ANACFG   = 10'h09F;

  // ========================================================================
  // Field positions.
  localparam int OPT_PU_DIS_N  = 7;
  localparam int OPT_EDGE_SEL  = 6;
  localparam int ICTL_CHG_FLAG = 0;
  localparam int ICTL_EXT_FLAG = 1;
  localparam int E_PSP_SEL     = 4;
  localparam int A_TMR_PIN     = 4;

  // ========================================================================
  // Reset values and masks.
  localparam logic [7:0] OPTION_RST  = 8'hFF;
  localparam logic [5:0] A_DIR_RST   = 6'h3F;
  localparam logic [7:0] B_DIR_RST   = 8'hFF;
  localparam logic [7:0] C_DIR_RST   = 8'hFF;
  localparam logic [7:0] D_DIR_RST   = 8'hFF;
  localparam logic [7:0] E_DIR_RST   = 8'h07;
  localparam logic [7:0] E_DIR_MASK  = 8'h17;
  localparam logic [5:0] A_ANA_MASK  = 6'h2F;
  localparam logic [1:0] ANA_DIGITAL = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ========================================================================
  // State carriers.
  typedef struct packed {
    logic [5:0] a_lat;
    logic [5:0] a_dir;
    logic [7:0] b_lat;
    logic [7:0] b_dir;
    logic [7:0] c_lat;
    logic [7:0] c_dir;
    logic [7:0] d_lat;
    logic [7:0] d_dir;
    logic [7:0] e_dir;
    logic [7:0] opt;
    logic [3:0] anacfg;
    logic [3:0] b_snap;
    logic       chg_flag;
    logic       ext_flag;
  } mpgio_regs_s;

  typedef struct packed {
    logic [29:0] s1;
    logic [29:0] s2;
    logic [29:0] s3;
    logic [29:0] stbl;
    logic        b0_prev;
  } mpgio_sync_s;

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [11:0] aw_addr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } mpgio_axi_s;

  typedef struct packed {
    mpgio_regs_s regs;
    mpgio_sync_s sync;
    mpgio_axi_s  axi;
  } mpgio_state_s;

endpackage : mpgio_pkg

/* hdl/mpgio_top.sv */
// Multi-port GPIO block with keypad change detection, AXI4-Lite registers.
`timescale 1ns/1ps
module mpgio_top (
  input  wire logic        CLK,            // Core clock, 200 MHz.
  input  wire logic        RST_N,          // Asynchronous reset, active low.
  input  wire logic        CE,             // Clock enable; low freezes all state.
  input  wire logic [11:0] AWADDR,         // Write address.
  input  wire logic        AWVALID,        // Write address valid.
  output logic             AWREADY,        // Write address ready.
  input  wire logic [31:0] WDATA,          // Write data.
  input  wire logic [3:0]  WSTRB,          // Write strobes.
  input  wire logic        WVALID,         // Write data valid.
  output logic             WREADY,         // Write data ready.
  output logic [1:0]       BRESP,          // Write response.
  output logic             BVALID,         // Write response valid.
  input  wire logic        BREADY,         // Write response ready.
  input  wire logic [11:0] ARADDR,         // Read address.
  input  wire logic        ARVALID,        // Read address valid.
  output logic             ARREADY,        // Read address ready.
  output logic [31:0]      RDATA,          // Read data.
  output logic [1:0]       RRESP,          // Read response.
  output logic             RVALID,         // Read data valid.
  input  wire logic        RREADY,         // Read data ready.
  input  wire logic [5:0]  PA_IN,          // Six-bit port pin levels.
  output logic [5:0]       PA_OUT,         // Six-bit port drive values.
  output logic [5:0]       PA_OE,          // Six-bit port drive enables.
  input  wire logic [7:0]  PB_IN,          // Keypad port pin levels.
  output logic [7:0]       PB_OUT,         // Keypad port drive values.
  output logic [7:0]       PB_OE,          // Keypad port drive enables.
  output logic [7:0]       PB_PULLUP,      // Keypad weak pull-up enables.
  input  wire logic [7:0]  PC_IN,          // Peripheral port pin levels.
  output logic [7:0]       PC_OUT,         // Peripheral port drive values.
  output logic [7:0]       PC_OE,          // Peripheral port drive enables.
  input  wire logic [7:0]  PD_IN,          // Fourth port pin levels.
  output logic [7:0]       PD_OUT,         // Fourth port drive values.
  output logic [7:0]       PD_OE,          // Fourth port drive enables.
  input  wire logic [7:0]  PERIPH_SEL,     // Peripheral owns pin.
  input  wire logic [7:0]  PERIPH_OUT,     // Peripheral output data.
  input  wire logic [7:0]  PERIPH_OE,      // Peripheral output enable.
  input  wire logic [7:0]  PERIPH_DIR_OVR, // Peripheral overrides direction.
  input  wire logic [7:0]  PERIPH_DIR_VAL, // Override value, one is input.
  input  wire logic        SLEEP,          // Core is asleep.
  output logic             WAKE,           // Wake request from change flag.
  output logic             EXT_INT_EVT,    // Selected edge seen on pin zero.
  output logic             TIMER_ZERO_EXT_CLOCK, // Timer clock from pin.
  output logic [4:0]       ANALOG_SEL,     // Analog function on pins.
  output logic             ANALOG_VREF_SEL, // Pin three as reference.
  input  wire logic        LOW_VOLTAGE_PROGRAMMING, // Programming pins on.
  output logic             PROGRAM_ENABLE_PIN, // Programming enable level.
  output logic             PROGRAM_CLOCK_PIN,  // Programming clock level.
  output logic             PROGRAM_DATA_PIN,   // Programming data level.
  output logic             PARALLEL_SLAVE_SELECT // Fourth port slave mode.
);

  // ========================================================================
  // State.
  mpgio_pkg::mpgio_state_s st_ff;
  mpgio_pkg::mpgio_state_s nxt_st;

  logic [29:0] diff;
  logic [5:0]  pa;
  logic [7:0]  pb;
  logic [7:0]  pc;
  logic [7:0]  pd;
  logic        ana_digital;
  logic [7:0]  c_eff_dir;
  logic [3:0]  mism;
  logic        edge_hit;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        ar_take;
  logic [11:0] wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_lane;
  logic [9:0]  widx;
  logic [9:0]  ridx;
  logic [7:0]  rd_val;
  logic        rd_ok;
  logic        wr_ok;
  logic        b_touch;

  assign pa = st_ff.sync.stbl[5:0];
  assign pb = st_ff.sync.stbl[13:6];
  assign pc = st_ff.sync.stbl[21:14];
  assign pd = st_ff.sync.stbl[29:22];
  assign ana_digital = (st_ff.regs.anacfg[2:1] == mpgio_pkg::ANA_DIGITAL);

  // ========================================================================
  // Bus handshakes; ready drops while CE is low so nothing is taken.
  assign AWREADY = CE & ~st_ff.axi.aw_got & ~st_ff.axi.bvalid;
  assign WREADY  = CE & ~st_ff.axi.w_got & ~st_ff.axi.bvalid;
  assign ARREADY = CE & ~st_ff.axi.rvalid;
  assign aw_take = AWVALID & AWREADY;
  assign w_take  = WVALID & WREADY;
  assign ar_take = ARVALID & ARREADY;
  assign wr_fire = (st_ff.axi.aw_got | aw_take) & (st_ff.axi.w_got | w_take);
  assign wr_addr = st_ff.axi.aw_got ? st_ff.axi.aw_addr : AWADDR;
  assign wr_byte = st_ff.axi.w_got ? st_ff.axi.wdata : WDATA[7:0];
  assign wr_lane = st_ff.axi.w_got ? st_ff.axi.wstrb0 : WSTRB[0];
  assign widx    = wr_addr[11:2];
  assign ridx    = ARADDR[11:2];

  assign BVALID = st_ff.axi.bvalid;
  assign BRESP  = st_ff.axi.bresp;
  assign RVALID = st_ff.axi.rvalid;
  assign RRESP  = st_ff.axi.rresp;
  assign RDATA  = {24'h000000, st_ff.axi.rdata};

  // ========================================================================
  // Read decode; data registers show the synchronised pin levels, except port A analog pins, which read zero.
  always_comb begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    unique case (ridx)
      mpgio_pkg::IDX_A_DATA: begin
        rd_val = {2'h0, pa & ~(ana_digital ? 6'h00 : mpgio_pkg::A_ANA_MASK)};
      end
      mpgio_pkg::IDX_B_DATA, mpgio_pkg::IDX_B_DATA_M: begin
        rd_val = pb;
      end
      mpgio_pkg::IDX_C_DATA: begin
        rd_val = pc;
      end
      mpgio_pkg::IDX_D_DATA: begin
        rd_val = pd;
      end
      mpgio_pkg::IDX_INTCTL, mpgio_pkg::IDX_INTCTL_M: begin
        rd_val = {6'h00, st_ff.regs.ext_flag, st_ff.regs.chg_flag};
      end
      mpgio_pkg::IDX_OPTION, mpgio_pkg::IDX_OPTION_M: begin
        rd_val = st_ff.regs.opt;
      end
      mpgio_pkg::IDX_A_DIR: begin
        rd_val = {2'h0, st_ff.regs.a_dir};
      end
      mpgio_pkg::IDX_B_DIR, mpgio_pkg::IDX_B_DIR_M: begin
        rd_val = st_ff.regs.b_dir;
      end
      mpgio_pkg::IDX_C_DIR: begin
        rd_val = st_ff.regs.c_dir;
      end
      mpgio_pkg::IDX_D_DIR: begin
        rd_val = st_ff.regs.d_dir;
      end
      mpgio_pkg::IDX_E_DIR: begin
        rd_val = st_ff.regs.e_dir;
      end
      mpgio_pkg::IDX_ANACFG: begin
        rd_val = {4'h0, st_ff.regs.anacfg};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // Next state.
  always_comb begin
    nxt_st = st_ff;
    wr_ok  = 1'b1;

    nxt_st.sync.s1 = {PD_IN, PC_IN, PB_IN, PA_IN};
    nxt_st.sync.s2 = st_ff.sync.s1;
    nxt_st.sync.s3 = st_ff.sync.s2;
    diff = st_ff.sync.s2 ^ st_ff.sync.s3;
    nxt_st.sync.stbl = (st_ff.sync.s3 & ~diff) | (st_ff.sync.stbl & diff);
    nxt_st.sync.b0_prev = pb[0];

    edge_hit = st_ff.regs.opt[mpgio_pkg::OPT_EDGE_SEL] ?
               (pb[0] & ~st_ff.sync.b0_prev) : (~pb[0] & st_ff.sync.b0_prev);

    mism = (pb[7:4] ^ st_ff.regs.b_snap) & st_ff.regs.b_dir[7:4];

    // Write channel capture when only one half has arrived.
    if (aw_take & ~wr_fire) begin
      nxt_st.axi.aw_got  = 1'b1;
      nxt_st.axi.aw_addr = AWADDR;
    end
    if (w_take & ~wr_fire) begin
      nxt_st.axi.w_got  = 1'b1;
      nxt_st.axi.wdata  = WDATA[7:0];
      nxt_st.axi.wstrb0 = WSTRB[0];
    end

    b_touch = 1'b0;
    if (wr_fire) begin
      nxt_st.axi.aw_got = 1'b0;
      nxt_st.axi.w_got  = 1'b0;
      nxt_st.axi.bvalid = 1'b1;
      unique case (widx)
        mpgio_pkg::IDX_A_DATA: begin
          if (wr_lane) nxt_st.regs.a_lat = wr_byte[5:0];
        end
        mpgio_pkg::IDX_B_DATA, mpgio_pkg::IDX_B_DATA_M: begin
          if (wr_lane) nxt_st.regs.b_lat = wr_byte;
          b_touch = 1'b1;
        end
        mpgio_pkg::IDX_C_DATA: begin
          if (wr_lane) nxt_st.regs.c_lat = wr_byte;
        end
        mpgio_pkg::IDX_D_DATA: begin
          if (wr_lane) nxt_st.regs.d_lat = wr_byte;
        end
        mpgio_pkg::IDX_INTCTL, mpgio_pkg::IDX_INTCTL_M: begin
          if (wr_lane) begin
            nxt_st.regs.chg_flag = wr_byte[mpgio_pkg::ICTL_CHG_FLAG];
            nxt_st.regs.ext_flag = wr_byte[mpgio_pkg::ICTL_EXT_FLAG];
          end
        end
        mpgio_pkg::IDX_OPTION, mpgio_pkg::IDX_OPTION_M: begin
          if (wr_lane) nxt_st.regs.opt = wr_byte;
        end
        mpgio_pkg::IDX_A_DIR: begin
          if (wr_lane) nxt_st.regs.a_dir = wr_byte[5:0];
        end
        mpgio_pkg::IDX_B_DIR, mpgio_pkg::IDX_B_DIR_M: begin
          if (wr_lane) nxt_st.regs.b_dir = wr_byte;
        end
        mpgio_pkg::IDX_C_DIR: begin
          if (wr_lane) nxt_st.regs.c_dir = wr_byte;
        end
        mpgio_pkg::IDX_D_DIR: begin
          if (wr_lane) nxt_st.regs.d_dir = wr_byte;
        end
        mpgio_pkg::IDX_E_DIR: begin
          if (wr_lane) nxt_st.regs.e_dir = wr_byte & mpgio_pkg::E_DIR_MASK;
        end
        mpgio_pkg::IDX_ANACFG: begin
          if (wr_lane) nxt_st.regs.anacfg = wr_byte[3:0];
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      nxt_st.axi.bresp = wr_ok ? mpgio_pkg::RESP_OKAY : mpgio_pkg::RESP_SLVERR;
    end else if (st_ff.axi.bvalid & BREADY & CE) begin
      nxt_st.axi.bvalid = 1'b0;
    end

    if (ar_take) begin
      nxt_st.axi.rvalid = 1'b1;
      nxt_st.axi.rdata  = rd_val;
      nxt_st.axi.rresp  = rd_ok ? mpgio_pkg::RESP_OKAY : mpgio_pkg::RESP_SLVERR;
      if ((ridx == mpgio_pkg::IDX_B_DATA) || (ridx == mpgio_pkg::IDX_B_DATA_M)) begin
        b_touch = 1'b1;
      end
    end else if (st_ff.axi.rvalid & RREADY & CE) begin
      nxt_st.axi.rvalid = 1'b0;
    end

    // The snapshot takes the same pin values that the read returns.
    if (b_touch) begin
      nxt_st.regs.b_snap = pb[7:4];
    end

    // A hardware set lands after a software clear, so the set wins.
    // flag set while mismatch
    if (|mism) begin
      nxt_st.regs.chg_flag = 1'b1;
    end
    if (edge_hit) begin
      nxt_st.regs.ext_flag = 1'b1;
    end
  end

  // ========================================================================
  // State register; CE low holds every bit.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= '0;
      st_ff.regs.opt   <= mpgio_pkg::OPTION_RST;
      st_ff.regs.b_dir <= mpgio_pkg::B_DIR_RST;
      st_ff.regs.a_dir <= mpgio_pkg::A_DIR_RST;
      st_ff.regs.c_dir <= mpgio_pkg::C_DIR_RST;
      st_ff.regs.d_dir <= mpgio_pkg::D_DIR_RST;
      st_ff.regs.e_dir <= mpgio_pkg::E_DIR_RST;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // Six-bit port pins.
  always_comb begin
    PA_OUT = st_ff.regs.a_lat;
    PA_OE  = ~st_ff.regs.a_dir;
    PA_OUT[mpgio_pkg::A_TMR_PIN] = 1'b0;
    PA_OE[mpgio_pkg::A_TMR_PIN]  = ~st_ff.regs.a_dir[mpgio_pkg::A_TMR_PIN] &
                                   ~st_ff.regs.a_lat[mpgio_pkg::A_TMR_PIN];
  end

  assign TIMER_ZERO_EXT_CLOCK = pa[mpgio_pkg::A_TMR_PIN];
  assign ANALOG_SEL      = ana_digital ? 5'h00 : 5'h1F;
  assign ANALOG_VREF_SEL = ~ana_digital & st_ff.regs.anacfg[0];

  // ========================================================================
  // Keypad port pins; programming mode takes pins three, six and seven.
  always_comb begin
    PB_OUT = st_ff.regs.b_lat;
    PB_OE  = ~st_ff.regs.b_dir;
    if (LOW_VOLTAGE_PROGRAMMING) begin
      PB_OE[3] = 1'b0;
      PB_OE[6] = 1'b0;
      PB_OE[7] = 1'b0;
    end
    PB_PULLUP = {8{~st_ff.regs.opt[mpgio_pkg::OPT_PU_DIS_N]}} & ~PB_OE;
  end

  assign PROGRAM_ENABLE_PIN = LOW_VOLTAGE_PROGRAMMING & pb[3];
  assign PROGRAM_CLOCK_PIN  = LOW_VOLTAGE_PROGRAMMING & pb[6];
  assign PROGRAM_DATA_PIN   = LOW_VOLTAGE_PROGRAMMING & pb[7];
  assign WAKE        = SLEEP & st_ff.regs.chg_flag;
  assign EXT_INT_EVT = edge_hit;

  // ========================================================================
  // Peripheral port pins.
  // peripheral overrides direction
  assign c_eff_dir = (PERIPH_DIR_OVR & PERIPH_DIR_VAL) |
                     (~PERIPH_DIR_OVR & st_ff.regs.c_dir);
  // select gates peripheral data and enable
  assign PC_OUT = (PERIPH_SEL & PERIPH_OUT) | (~PERIPH_SEL & st_ff.regs.c_lat);
  assign PC_OE  = (PERIPH_SEL & PERIPH_OE) | (~PERIPH_SEL & ~c_eff_dir);

  // ========================================================================
  // Fourth port; the slave handshake lives elsewhere, so drivers stay off in slave mode.
  // slave select from fifth direction
  assign PARALLEL_SLAVE_SELECT = st_ff.regs.e_dir[mpgio_pkg::E_PSP_SEL];
  assign PD_OUT = st_ff.regs.d_lat;
  assign PD_OE  = PARALLEL_SLAVE_SELECT ? 8'h00 : ~st_ff.regs.d_dir;

endmodule : mpgio_top

/* verif/mpgio_assertions.sv */
// Port-level checks for the multi-port GPIO block.
`timescale 1ns/1ps
module mpgio_assertions (
  input wire logic        CLK,                     // Clock.
  input wire logic        RST_N,                   // Reset.
  input wire logic        AWVALID,                 // Bus.
  input wire logic        AWREADY,                 // Bus.
  input wire logic        WVALID,                  // Bus.
  input wire logic        WREADY,                  // Bus.
  input wire logic        BVALID,                  // Bus.
  input wire logic        BREADY,                  // Bus.
  input wire logic        ARVALID,                 // Bus.
  input wire logic        ARREADY,                 // Bus.
  input wire logic        RVALID,                  // Bus.
  input wire logic        RREADY,                  // Bus.
  input wire logic [31:0] RDATA,                   // Bus.
  input wire logic [5:0]  PA_OUT,                  // Pins.
  input wire logic [7:0]  PB_OE,                   // Pins.
  input wire logic [7:0]  PB_PULLUP,               // Pins.
  input wire logic [7:0]  PC_OUT,                  // Pins.
  input wire logic [7:0]  PD_OE,                   // Pins.
  input wire logic [7:0]  PERIPH_SEL,              // Peripheral.
  input wire logic [7:0]  PERIPH_OUT,              // Peripheral.
  input wire logic        SLEEP,                   // Sleep.
  input wire logic        WAKE,                    // Wake.
  input wire logic        LOW_VOLTAGE_PROGRAMMING, // Programming on.
  input wire logic        PROGRAM_CLOCK_PIN,       // Programming clock.
  input wire logic        PARALLEL_SLAVE_SELECT    // Slave mode.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_WR_RESP: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
    else $error("Write got no response.");
  AST_RD_RESP: assert property (ARVALID && ARREADY |=> RVALID && RDATA[31:8] == 24'h0)
    else $error("Read got no response.");
  AST_RD_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("Read data dropped early.");
  AST_RD_BUSY: assert property (RVALID |-> !ARREADY)
    else $error("Read taken while busy.");
  AST_PU_OUT: assert property ((PB_PULLUP & PB_OE) == 8'h00)
    else $error("Pull-up on driven pin.");
  AST_WAKE: assert property (WAKE |-> SLEEP)
    else $error("Wake while awake.");
  AST_OPEN_DRAIN: assert property (PA_OUT[4] == 1'b0)
    else $error("Timer pin drives high.");
  AST_PERIPH_MUX: assert property (((PC_OUT ^ PERIPH_OUT) & PERIPH_SEL) == 8'h00)
    else $error("Peripheral data not routed.");
  AST_SLAVE_MODE: assert property (PARALLEL_SLAVE_SELECT |-> PD_OE == 8'h00)
    else $error("Fourth port drives in slave mode.");
  AST_PROG_CLK: assert property (PROGRAM_CLOCK_PIN |-> LOW_VOLTAGE_PROGRAMMING)
    else $error("Programming clock while off.");
  cover property (BVALID && BREADY);
  cover property (RVALID && RREADY);
  cover property (WAKE);
endmodule : mpgio_assertions

bind mpgio_top mpgio_assertions i_chk (.*);

/* verif/mpgio_pins.sv */
// Board-side model of one port: resolves each pin from all its drivers.
`timescale 1ns/1ps
module mpgio_pins #(
  parameter int W = 8 // Pin count.
) (
  input  wire logic         CLK, // Core clock.
  input  wire logic [W-1:0] OE,  // Block drives pin.
  input  wire logic [W-1:0] OUT, // Block drive value.
  input  wire logic [W-1:0] PU,  // Weak pull-up on.
  input  wire logic [W-1:0] DRV, // Board device drives pin.
  input  wire logic [W-1:0] VAL, // Board device value.
  output logic      [W-1:0] PIN  // Resolved pin level.
);
  logic [W-1:0] flt_ff;
  // A floating pin keeps toggling, so a stale level never passes for a real one.
  always_ff @(posedge CLK) begin
    flt_ff <= ~PIN;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      PIN[i] = OE[i] ? OUT[i] : DRV[i] ? VAL[i] : PU[i] ? 1'b1 : flt_ff[i];
    end
  end
endmodule : mpgio_pins

/* verif/multi_port_gpio_with_change_irq_bench.sv */
// Self-checking bench for the multi-port GPIO block.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module multi_port_gpio_with_change_irq_bench;
  logic        CLK, RST_N, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, WAKE, EXT_INT_EVT;
  logic        LOW_VOLTAGE_PROGRAMMING, PROGRAM_ENABLE_PIN, PROGRAM_CLOCK_PIN;
  logic        PROGRAM_DATA_PIN, PARALLEL_SLAVE_SELECT, TIMER_ZERO_EXT_CLOCK;
  logic        ANALOG_VREF_SEL;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rr;
  logic [4:0]  ANALOG_SEL;
  logic [5:0]  PA_IN, PA_OUT, PA_OE, a_val;
  logic [7:0]  PB_IN, PB_OUT, PB_OE, PB_PULLUP, PC_IN, PC_OUT, PC_OE, PD_IN, PD_OUT, PD_OE;
  logic [7:0]  PERIPH_SEL, PERIPH_OUT, PERIPH_OE, PERIPH_DIR_OVR, PERIPH_DIR_VAL;
  logic [7:0]  b_drv, b_val, c_val, d_val, rdv;
  int          bad_count = 0, checked = 0, cyc = 0, evts = 0, e0;

  mpgio_top i_dut (.*);
  mpgio_pins #(.W(6)) i_pa (.CLK(CLK), .OE(PA_OE), .OUT(PA_OUT), .PU(6'h00),
    .DRV(~PA_OE), .VAL(a_val), .PIN(PA_IN));
  mpgio_pins #(.W(8)) i_pb (.CLK(CLK), .OE(PB_OE), .OUT(PB_OUT), .PU(PB_PULLUP),
    .DRV(b_drv), .VAL(b_val), .PIN(PB_IN));
  mpgio_pins #(.W(8)) i_pc (.CLK(CLK), .OE(PC_OE), .OUT(PC_OUT), .PU(8'h00),
    .DRV(~PC_OE), .VAL(c_val), .PIN(PC_IN));
  mpgio_pins #(.W(8)) i_pd (.CLK(CLK), .OE(PD_OE), .OUT(PD_OUT), .PU(8'h00),
    .DRV(~PD_OE), .VAL(d_val), .PIN(PD_IN));

  // ==========================================================================
  // Clock, watchdog and event counter
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (EXT_INT_EVT === 1'b1) evts <= evts + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Bus tasks; each starts on a fresh edge so no signal is driven twice at once.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge CLK);
    AWADDR  <= {idx, 2'h0};
    WDATA   <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    @(negedge CLK);
    while (!AWREADY || !WREADY) @(negedge CLK);
    @(posedge CLK);
    AWVALID <= 1'b0;
    WVALID  <= 1'b0;
    @(negedge CLK);
    while (!BVALID) @(negedge CLK);
    rr = BRESP;
    @(posedge CLK);
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    @(posedge CLK);
    ARADDR  <= {idx, 2'h0};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    @(negedge CLK);
    while (!ARREADY) @(negedge CLK);
    @(posedge CLK);
    ARVALID <= 1'b0;
    @(negedge CLK);
    while (!RVALID) @(negedge CLK);
    rdv = RDATA[7:0];
    rr  = RRESP;
    @(posedge CLK);
    RREADY <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
    rd(idx);
    `CHK(rdv, e)
  endtask : rchk

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // ==========================================================================
  // Main sequence
  initial begin
    {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP} = '0;
    {LOW_VOLTAGE_PROGRAMMING, AWADDR, ARADDR, WDATA} = '0;
    {PERIPH_SEL, PERIPH_OUT, PERIPH_OE, PERIPH_DIR_OVR, PERIPH_DIR_VAL} = '0;
    {CE, WSTRB, a_val, b_drv, b_val} = {1'b1, 4'hF, 6'h3F, 8'hFF, 8'h00};
    {c_val, d_val} = {8'h00, 8'h96};
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    `CHK(PB_PULLUP, 8'h00)
    `CHK({ANALOG_VREF_SEL, ANALOG_SEL}, 6'h1F)
    rchk(mpgio_pkg::IDX_OPTION, 8'hFF);
    rchk(mpgio_pkg::IDX_B_DIR_M, 8'hFF);
    rchk(mpgio_pkg::IDX_C_DIR, 8'hFF);
    rchk(mpgio_pkg::IDX_A_DIR, 8'h3F);
    rchk(mpgio_pkg::IDX_A_DATA, 8'h10);
    rd(10'h0FF);
    `CHK(rr, mpgio_pkg::RESP_SLVERR)
    wr(10'h0FF, 8'h00);
    `CHK(rr, mpgio_pkg::RESP_SLVERR)
    wr(mpgio_pkg::IDX_ANACFG, 8'h06);
    `CHK(rr, mpgio_pkg::RESP_OKAY)
    `CHK({ANALOG_VREF_SEL, ANALOG_SEL}, 6'h00)
    wr(mpgio_pkg::IDX_A_DIR, 8'hFF);
    rchk(mpgio_pkg::IDX_A_DIR, 8'h3F);
    rchk(mpgio_pkg::IDX_A_DATA, 8'h3F);
    `CHK(TIMER_ZERO_EXT_CLOCK, 1'b1)
    a_val <= 6'h3A;
    wr(mpgio_pkg::IDX_A_DIR, 8'h2F);
    `CHK(PA_OE, 6'h10)
    repeat (8) @(posedge CLK);
    `CHK(TIMER_ZERO_EXT_CLOCK, 1'b0)
    rchk(mpgio_pkg::IDX_A_DATA, 8'h2A);
    wr(mpgio_pkg::IDX_OPTION_M, 8'h7F);
    `CHK(PB_PULLUP, 8'hFF)
    wr(mpgio_pkg::IDX_B_DATA, 8'hA0);
    wr(mpgio_pkg::IDX_B_DIR, 8'h0F);
    `CHK(PB_PULLUP, 8'h0F)
    `CHK({PB_OE, PB_OUT}, 16'hF0A0)
    b_drv <= 8'h00;
    repeat (8) @(posedge CLK);
    rchk(mpgio_pkg::IDX_B_DATA_M, 8'hAF);
    b_drv <= 8'hFF;
    wr(mpgio_pkg::IDX_B_DIR, 8'hFF);
    repeat (8) @(posedge CLK);
    rd(mpgio_pkg::IDX_B_DATA);
    wr(mpgio_pkg::IDX_INTCTL, 8'h00);
    rchk(mpgio_pkg::IDX_INTCTL, 8'h00);
    SLEEP <= 1'b1;
    b_val <= 8'h02;
    repeat (8) @(posedge CLK);
    rchk(mpgio_pkg::IDX_INTCTL, 8'h00);
    b_val <= 8'h82;
    repeat (8) @(posedge CLK);
    `CHK(WAKE, 1'b1)
    rchk(mpgio_pkg::IDX_INTCTL_M, 8'h01);
    wr(mpgio_pkg::IDX_INTCTL, 8'h00);
    rchk(mpgio_pkg::IDX_INTCTL, 8'h01);
    wr(mpgio_pkg::IDX_B_DATA, 8'h00);
    wr(mpgio_pkg::IDX_INTCTL, 8'h00);
    rchk(mpgio_pkg::IDX_INTCTL, 8'h00);
    SLEEP <= 1'b0;
    e0 = evts;
    wr(mpgio_pkg::IDX_OPTION, 8'h40);
    b_val <= 8'h83;
    repeat (8) @(posedge CLK);
    b_val <= 8'h82;
    repeat (8) @(posedge CLK);
    `CHK(evts - e0, 1)
    wr(mpgio_pkg::IDX_OPTION, 8'h00);
    b_val <= 8'h83;
    repeat (8) @(posedge CLK);
    b_val <= 8'h82;
    repeat (8) @(posedge CLK);
    `CHK(evts - e0, 2)
    LOW_VOLTAGE_PROGRAMMING <= 1'b1;
    b_val <= 8'hC8;
    repeat (8) @(posedge CLK);
    `CHK({PROGRAM_ENABLE_PIN, PROGRAM_CLOCK_PIN, PROGRAM_DATA_PIN}, 3'h7)
    // Clock enable low must freeze the synchroniser and refuse the bus.
    c_val <= 8'h55;
    CE    <= 1'b0;
    repeat (8) @(posedge CLK);
    `CHK({AWREADY, WREADY, ARREADY}, 3'h0)
    CE <= 1'b1;
    rchk(mpgio_pkg::IDX_C_DATA, 8'h00);
    repeat (4) @(posedge CLK);
    rchk(mpgio_pkg::IDX_C_DATA, 8'h55);
    {PERIPH_SEL, PERIPH_OUT, PERIPH_OE, PERIPH_DIR_OVR, PERIPH_DIR_VAL} <= 40'hF05AC00F05;
    wr(mpgio_pkg::IDX_C_DATA, 8'h33);
    `CHK(PC_OUT, 8'h53)
    `CHK(PC_OE, 8'hCA)
    rchk(mpgio_pkg::IDX_C_DIR, 8'hFF);
    rchk(mpgio_pkg::IDX_D_DATA, 8'h96);
    wr(mpgio_pkg::IDX_D_DIR, 8'h00);
    wr(mpgio_pkg::IDX_D_DATA, 8'h3C);
    `CHK({PD_OE, PD_OUT}, 16'hFF3C)
    WSTRB <= 4'hE;
    wr(mpgio_pkg::IDX_D_DATA, 8'h00);
    WSTRB <= 4'hF;
    `CHK(PD_OUT, 8'h3C)
    rchk(mpgio_pkg::IDX_D_DATA, 8'h3C);
    wr(mpgio_pkg::IDX_E_DIR, 8'h10);
    `CHK({PARALLEL_SLAVE_SELECT, PD_OE}, 9'h100)
    summarize();
  end
endmodule : multi_port_gpio_with_change_irq_bench
